// >>> logic/ics_pkg.sv
package ics_pkg;

  // pixel bus lanes
  localparam int YCM_W      = 24;
  localparam int LANE_W     = 8;
  localparam int LUMA_LSB   = 0;
  localparam int CHROMA_LSB = 8;
  localparam int MOTION_LSB = 16;

  // configuration word layouts
  localparam int CFG_W        = 32;
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_UPD_BIT = 1;
  localparam int FDIM_W       = 11;
  localparam int FW_LSB       = 0;
  localparam int FH_LSB       = 16;
  localparam int BS_W         = 7;
  localparam int PIX_CNT_W    = 2 * FDIM_W;

  // legal block sizes
  localparam logic [BS_W-1:0] BS_4  = 7'h04;
  localparam logic [BS_W-1:0] BS_8  = 7'h08;
  localparam logic [BS_W-1:0] BS_16 = 7'h10;
  localparam logic [BS_W-1:0] BS_32 = 7'h20;
  localparam logic [BS_W-1:0] BS_64 = 7'h40;

  // reset values of the working copies
  localparam logic [BS_W-1:0]   BS_RST = 7'h10;
  localparam logic [FDIM_W-1:0] FW_RST = 11'h000;
  localparam logic [FDIM_W-1:0] FH_RST = 11'h000;

  // processing ticks taken to close the frame header after the last pixel
  localparam int             HDR_CNT_W = 3;
  localparam logic [2:0]     HDR_TICKS = 3'h4;

  // interrupt bits
  localparam int IRQ_W        = 2;
  localparam int IRQ_ERR_BIT  = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

  // apb register map
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFS_MODE       = 8'h00;
  localparam logic [APB_AW-1:0] OFS_IRQ_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] OFS_IRQ_MASK   = 8'h08;
  localparam logic [APB_AW-1:0] OFS_STATE      = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_FSIZE      = 8'h10;
  localparam logic [APB_AW-1:0] OFS_BSIZE      = 8'h14;
  localparam logic [APB_AW-1:0] OFS_PIXCNT     = 8'h18;
  localparam int MODE_STREAM_BIT = 0;

  typedef enum logic [1:0] {
    ICS_IDLE = 2'b00,
    ICS_RUN  = 2'b01,
    ICS_HDR  = 2'b10,
    ICS_DONE = 2'b11
  } ics_state_e;

endpackage

// >>> logic/ics_sync.sv
`timescale 1ns/1ps
module ics_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // ics_sync

// >>> logic/ics_top.sv
`timescale 1ns/1ps
module ics_top (
  input  wire logic                          CLOCK,
  input  wire logic                          RST,
  input  wire logic                          CE,
  input  wire logic                          SCLR,
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [ics_pkg::APB_AW-1:0]    PADDR,
  input  wire logic [31:0]                   PWDATA,
  output logic      [31:0]                   PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  input  wire logic                          VIDEO_CLK,
  input  wire logic                          CORE_CLK,
  input  wire logic [ics_pkg::YCM_W-1:0]     YCM_IN,
  input  wire logic                          ACTIVE_VIDEO_IN,
  input  wire logic                          VBLANK_IN,
  input  wire logic                          CHROMA_IN,
  input  wire logic [ics_pkg::CFG_W-1:0]     CONTROL,
  input  wire logic [ics_pkg::CFG_W-1:0]     FRAME_SIZE,
  input  wire logic [ics_pkg::CFG_W-1:0]     BLOCK_SIZE,
  output logic                               FRAME_DONE,
  output logic                               FRAME_ERROR,
  output logic                               REG_UPDATE_DONE,
  output logic                               IRQ_OUT,
  output logic      [ics_pkg::LANE_W-1:0]    LUMA_OUT,
  output logic      [ics_pkg::LANE_W-1:0]    CHROMA_OUT,
  output logic      [ics_pkg::LANE_W-1:0]    MOTION_OUT,
  output logic                               PIXEL_STROBE
);
  import ics_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: link clocks are sampled, never used as clocks
  localparam int SYN_W = YCM_W + 5;
  logic [SYN_W-1:0] syn_q;
  logic             vclk_s;
  logic             cclk_s;
  logic             vblank_s;
  logic             active_s;
  logic             chroma_s;
  logic [YCM_W-1:0] ycm_s;

  ics_sync #(.W(SYN_W)) u_sync (
    .clk (CLOCK),
    .rst (RST),
    .d   ({VIDEO_CLK, CORE_CLK, VBLANK_IN, ACTIVE_VIDEO_IN, CHROMA_IN, YCM_IN}),
    .q   (syn_q)
  );

  assign {vclk_s, cclk_s, vblank_s, active_s, chroma_s, ycm_s} = syn_q;

  ////////////////////////////////////////////////////////////////////////////
  // core state
  ics_state_e          state_q,   state_d;
  logic                vclk_p_q,  vclk_p_d;
  logic                cclk_p_q,  cclk_p_d;
  logic                vblk_p_q,  vblk_p_d;
  logic                en_q,      en_d;
  logic [FDIM_W-1:0]   fw_q,      fw_d;
  logic [FDIM_W-1:0]   fh_q,      fh_d;
  logic [BS_W-1:0]     bs_q,      bs_d;
  logic [PIX_CNT_W-1:0] pix_q,    pix_d;
  logic [HDR_CNT_W-1:0] hdr_q,    hdr_d;
  logic                done_q,    done_d;
  logic                err_q,     err_d;
  logic                upd_q,     upd_d;
  logic                stb_q,     stb_d;
  logic [LANE_W-1:0]   luma_q,    luma_d;
  logic [LANE_W-1:0]   chr_q,     chr_d;
  logic [LANE_W-1:0]   mot_q,     mot_d;
  logic                ev_err;
  logic                ev_done;
  logic                mode_stream_q;

  logic                video_rise;
  logic                core_rise;
  logic                proc_tick;
  logic                vblank_fall;
  logic                bs_ok;
  logic                new_en;
  logic [PIX_CNT_W-1:0] area;

  assign video_rise  = vclk_s & ~vclk_p_q;
  assign core_rise   = cclk_s & ~cclk_p_q;
  // processing pace follows the core clock only in streaming mode
  assign proc_tick   = mode_stream_q ? core_rise : video_rise;
  // vblank is qualified by the video clock, as the source drives it there
  assign vblank_fall = video_rise & vblk_p_q & ~vblank_s;
  assign area        = fw_q * fh_q;

  always_comb begin
    case (BLOCK_SIZE[BS_W-1:0])
      BS_4, BS_8, BS_16, BS_32, BS_64: bs_ok = 1'b1;
      default:                         bs_ok = 1'b0;
    endcase
  end

  // enable sampled only at the frame boundary
  assign new_en = CONTROL[CTRL_UPD_BIT] ? CONTROL[CTRL_EN_BIT] : en_q;

  always_comb begin
    state_d  = state_q;
    vclk_p_d = vclk_p_q;
    cclk_p_d = cclk_p_q;
    vblk_p_d = vblk_p_q;
    en_d     = en_q;
    fw_d     = fw_q;
    fh_d     = fh_q;
    bs_d     = bs_q;
    pix_d    = pix_q;
    hdr_d    = hdr_q;
    done_d   = done_q;
    err_d    = err_q;
    upd_d    = 1'b0;
    stb_d    = 1'b0;
    luma_d   = luma_q;
    chr_d    = chr_q;
    mot_d    = mot_q;
    ev_err   = 1'b0;
    ev_done  = 1'b0;
    if (SCLR) begin
      state_d = ICS_IDLE;
      en_d    = 1'b0;
      fw_d    = FW_RST;
      fh_d    = FH_RST;
      bs_d    = BS_RST;
      pix_d   = '0;
      hdr_d   = '0;
      done_d  = 1'b0;
      err_d   = 1'b0;
    end else if (CE) begin
      vclk_p_d = vclk_s;
      cclk_p_d = cclk_s;
      if (video_rise) begin
        vblk_p_d = vblank_s;
      end
      if (vblank_fall) begin
        // the controller keeps inputs stable while update enable is set
        if (CONTROL[CTRL_UPD_BIT]) begin
          en_d  = CONTROL[CTRL_EN_BIT];
          fw_d  = FRAME_SIZE[FW_LSB +: FDIM_W];
          fh_d  = FRAME_SIZE[FH_LSB +: FDIM_W];
          // an illegal block size keeps the old one and flags an error
          if (bs_ok) begin
            bs_d = BLOCK_SIZE[BS_W-1:0];
          end
          upd_d = 1'b1;
        end
        ev_err  = (state_q == ICS_RUN) || (state_q == ICS_HDR) || (CONTROL[CTRL_UPD_BIT] && !bs_ok);
        err_d   = ev_err;
        done_d  = 1'b0;
        pix_d   = '0;
        hdr_d   = '0;
        state_d = new_en ? ICS_RUN : ICS_IDLE;
      end else begin
        case (state_q)
          ICS_RUN: begin
            if (video_rise && active_s) begin
              stb_d  = 1'b1;
              luma_d = ycm_s[LUMA_LSB +: LANE_W];
              mot_d  = ycm_s[MOTION_LSB +: LANE_W];
              if (chroma_s) begin
                chr_d = ycm_s[CHROMA_LSB +: LANE_W];
              end
              pix_d = pix_q + 1'b1;
              if (pix_d == area) begin
                state_d = ICS_HDR;
              end
            end
          end
          ICS_HDR: begin
            if (proc_tick) begin
              hdr_d = hdr_q + 1'b1;
              if (hdr_q == HDR_TICKS - 1'b1) begin
                state_d = ICS_DONE;
                done_d  = 1'b1;
                ev_done = 1'b1;
              end
            end
          end
          ICS_DONE: state_d = ICS_DONE;
          ICS_IDLE: state_d = ICS_IDLE;
          default:  state_d = ICS_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_q  <= ICS_IDLE;
      vclk_p_q <= 1'b0;
      cclk_p_q <= 1'b0;
      vblk_p_q <= 1'b0;
      en_q     <= 1'b0;
      fw_q     <= FW_RST;
      fh_q     <= FH_RST;
      bs_q     <= BS_RST;
      pix_q    <= '0;
      hdr_q    <= '0;
      done_q   <= 1'b0;
      err_q    <= 1'b0;
      upd_q    <= 1'b0;
      stb_q    <= 1'b0;
      luma_q   <= '0;
      chr_q    <= '0;
      mot_q    <= '0;
    end else begin
      state_q  <= state_d;
      vclk_p_q <= vclk_p_d;
      cclk_p_q <= cclk_p_d;
      vblk_p_q <= vblk_p_d;
      en_q     <= en_d;
      fw_q     <= fw_d;
      fh_q     <= fh_d;
      bs_q     <= bs_d;
      pix_q    <= pix_d;
      hdr_q    <= hdr_d;
      done_q   <= done_d;
      err_q    <= err_d;
      upd_q    <= upd_d;
      stb_q    <= stb_d;
      luma_q   <= luma_d;
      chr_q    <= chr_d;
      mot_q    <= mot_d;
    end
  end

  assign FRAME_DONE      = done_q;
  assign FRAME_ERROR     = err_q;
  assign REG_UPDATE_DONE = upd_q;
  assign PIXEL_STROBE    = stb_q;
  assign LUMA_OUT        = luma_q;
  assign CHROMA_OUT      = chr_q;
  assign MOTION_OUT      = mot_q;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait, read data prepared in the setup cycle
  logic             mode_stream_d;
  logic [IRQ_W-1:0] irq_sts_q, irq_sts_d;
  logic [IRQ_W-1:0] irq_enable_mask_q, irq_enable_mask_d;
  logic [31:0]      prdata_q, prdata_d;
  logic             slverr_q, slverr_d;
  logic [31:0]      rd_mux;
  logic             hit;
  logic             setup;
  logic             wr;
  logic [IRQ_W-1:0] events;

  assign setup = PSEL & ~PENABLE;
  assign wr    = PSEL & PENABLE & PWRITE;
  assign events = {ev_done, ev_err};

  always_comb begin
    rd_mux = 32'h0000_0000;
    hit    = 1'b1;
    case (PADDR)
      OFS_MODE:       rd_mux[MODE_STREAM_BIT] = mode_stream_q;
      OFS_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_sts_q;
      OFS_IRQ_MASK:   rd_mux[IRQ_W-1:0] = irq_enable_mask_q;
      OFS_STATE:      rd_mux[4:0] = {err_q, done_q, en_q, state_q};
      OFS_FSIZE: begin
        rd_mux[FW_LSB +: FDIM_W] = fw_q;
        rd_mux[FH_LSB +: FDIM_W] = fh_q;
      end
      OFS_BSIZE:      rd_mux[BS_W-1:0] = bs_q;
      OFS_PIXCNT:     rd_mux[PIX_CNT_W-1:0] = pix_q;
      default:        hit = 1'b0;
    endcase
  end

  always_comb begin
    mode_stream_d     = mode_stream_q;
    irq_enable_mask_d = irq_enable_mask_q;
    prdata_d          = prdata_q;
    slverr_d          = slverr_q;
    irq_sts_d         = irq_sts_q;
    if (setup) begin
      prdata_d = PWRITE ? 32'h0000_0000 : rd_mux;
      slverr_d = ~hit;
    end
    if (wr && PADDR == OFS_MODE) begin
      mode_stream_d = PWDATA[MODE_STREAM_BIT];
    end
    if (wr && PADDR == OFS_IRQ_MASK) begin
      irq_enable_mask_d = PWDATA[IRQ_W-1:0];
    end
    if (wr && PADDR == OFS_IRQ_STATUS) begin
      irq_sts_d = irq_sts_q & ~PWDATA[IRQ_W-1:0];
    end
    // a new event outranks a clear in the same cycle
    irq_sts_d = irq_sts_d | events;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      mode_stream_q     <= 1'b0;
      irq_enable_mask_q <= IRQ_MASK_RST;
      irq_sts_q         <= '0;
      prdata_q          <= 32'h0000_0000;
      slverr_q          <= 1'b0;
    end else begin
      mode_stream_q     <= mode_stream_d;
      irq_enable_mask_q <= irq_enable_mask_d;
      irq_sts_q         <= irq_sts_d;
      prdata_q          <= prdata_d;
      slverr_q          <= slverr_d;
    end
  end

  assign PREADY  = 1'b1;
  assign PRDATA  = prdata_q;
  assign PSLVERR = slverr_q & PSEL & PENABLE;
  assign IRQ_OUT = (irq_sts_q[IRQ_ERR_BIT] & irq_enable_mask_q[IRQ_ERR_BIT])
                 | (irq_sts_q[IRQ_DONE_BIT] & irq_enable_mask_q[IRQ_DONE_BIT]);

endmodule // ics_top

// >>> tb/ics_top_asserts.sv
`timescale 1ns/1ps
module ics_top_asserts (
  input wire logic                       CLOCK,
  input wire logic                       RST,
  input wire logic                       CE,
  input wire logic                       SCLR,
  input wire logic                       VBLANK_IN,
  input wire logic                       ACTIVE_VIDEO_IN,
  input wire logic [ics_pkg::CFG_W-1:0]  CONTROL,
  input wire logic                       FRAME_DONE,
  input wire logic                       FRAME_ERROR,
  input wire logic                       REG_UPDATE_DONE,
  input wire logic                       PIXEL_STROBE,
  input wire logic [ics_pkg::LANE_W-1:0] LUMA_OUT,
  input wire logic [ics_pkg::LANE_W-1:0] CHROMA_OUT
);
  import ics_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // working enable as the controller left it at the last frame start
  logic vb_q;
  logic en_w;
  always_ff @(posedge CLOCK) begin
    vb_q <= VBLANK_IN;
    if (RST || SCLR) begin
      en_w <= 1'b0;
    end else if (CE && vb_q && !VBLANK_IN && CONTROL[CTRL_UPD_BIT]) begin
      en_w <= CONTROL[CTRL_EN_BIT];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_sclr;
    SCLR |=> !FRAME_DONE && !FRAME_ERROR && !PIXEL_STROBE && !REG_UPDATE_DONE;
  endproperty
  a_sclr: assert property (p_sclr) else $error("clear left a flag set");
  // clear wins over a low enable, so it is left out here
  property p_ce_hold;
    !CE && !SCLR |=> $stable(FRAME_DONE) && $stable(FRAME_ERROR) && $stable(LUMA_OUT) && $stable(CHROMA_OUT);
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("state moved with enable low");
  property p_upd;
    REG_UPDATE_DONE |-> CONTROL[CTRL_UPD_BIT] && !VBLANK_IN ##1 !REG_UPDATE_DONE;
  endproperty
  a_upd: assert property (p_upd) else $error("bad update pulse");
  property p_done_hold;
    FRAME_DONE && VBLANK_IN && !SCLR |=> FRAME_DONE;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done dropped in blank");
  property p_done_fall;
    $fell(FRAME_DONE) |-> $past(SCLR) || !VBLANK_IN;
  endproperty
  a_done_fall: assert property (p_done_fall) else $error("done fell without frame start");
  property p_done_rise;
    $rose(FRAME_DONE) |-> !VBLANK_IN && !ACTIVE_VIDEO_IN;
  endproperty
  a_done_rise: assert property (p_done_rise) else $error("done rose outside frame end");
  property p_idle;
    !ACTIVE_VIDEO_IN [*8] |=> !PIXEL_STROBE;
  endproperty
  a_idle: assert property (p_idle) else $error("pixel taken without valid");
  property p_pulse;
    CE && PIXEL_STROBE |=> !PIXEL_STROBE;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pixel strobe too long");
  property p_en;
    PIXEL_STROBE |-> en_w;
  endproperty
  a_en: assert property (p_en) else $error("pixel taken while disabled");
endmodule // ics_top_asserts

// >>> tb/ics_vsrc.sv
`timescale 1ns/1ps
module ics_vsrc (
  output logic        vclk,
  output logic [23:0] ycm,
  output logic        act,
  output logic        vb,
  output logic        chr
);
  initial begin
    vclk = 1'b0;
    ycm = 24'h0;
    act = 1'b0;
    vb = 1'b0;
    chr = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // clock only runs within a frame, like a gated source
  task automatic tick();
    #40 vclk = 1'b1;
    #40 vclk = 1'b0;
  endtask
  task automatic frame(input int n);
    #2;
    vb = 1'b1;
    repeat (2) tick();
    vb = 1'b0;
    repeat (2) tick();
    for (int i = 0; i < n; i++) begin
      act = 1'b1;
      chr = ~i[0];
      ycm = {8'h5a, 8'h80 + 8'(i), 8'h10 + 8'(i)};
      tick();
    end
    act = 1'b0;
    chr = 1'b0;
    ycm = ~ycm;
    // trailing ticks give the header phase its processing ticks
    repeat (6) tick();
  endtask
endmodule // ics_vsrc

// >>> tb/ics_top_tb.sv
`timescale 1ns/1ps
bind ics_top ics_top_asserts u_ics_top_asserts (
  .CLOCK           (CLOCK),
  .RST             (RST),
  .CE              (CE),
  .SCLR            (SCLR),
  .VBLANK_IN       (VBLANK_IN),
  .ACTIVE_VIDEO_IN (ACTIVE_VIDEO_IN),
  .CONTROL         (CONTROL),
  .FRAME_DONE      (FRAME_DONE),
  .FRAME_ERROR     (FRAME_ERROR),
  .REG_UPDATE_DONE (REG_UPDATE_DONE),
  .PIXEL_STROBE    (PIXEL_STROBE),
  .LUMA_OUT        (LUMA_OUT),
  .CHROMA_OUT      (CHROMA_OUT)
);
module ics_top_tb;
  import ics_pkg::*;
  logic        CLOCK = 1'b0;
  logic        CORE_CLK = 1'b0;
  logic        core_on = 1'b0;
  int          upd_n = 0;
  logic        RST = 1'b1;
  logic        CE = 1'b1;
  logic        SCLR = 1'b0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] CONTROL = 32'h0;
  logic [31:0] FRAME_SIZE = 32'h0;
  logic [31:0] BLOCK_SIZE = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, VIDEO_CLK, ACTIVE_VIDEO_IN, VBLANK_IN, CHROMA_IN;
  logic        FRAME_DONE, FRAME_ERROR, REG_UPDATE_DONE, IRQ_OUT, PIXEL_STROBE;
  logic [23:0] YCM_IN;
  logic [7:0]  LUMA_OUT, CHROMA_OUT, MOTION_OUT;
  logic [31:0] rdat;
  logic        rerr;
  logic [6:0]  sizes [5] = '{BS_4, BS_8, BS_16, BS_32, BS_64};
  int          failures = 0;
  int          compares = 0;
  int          pix_i = 0;
  always #4 CLOCK = ~CLOCK;
  // core clock well below the sampling rate, and gated so a stalled header can be shown
  always #24 CORE_CLK = ~CORE_CLK & core_on;
  ics_top u_ics_top (
    .CLOCK           (CLOCK),
    .RST             (RST),
    .CE              (CE),
    .SCLR            (SCLR),
    .PSEL            (PSEL),
    .PENABLE         (PENABLE),
    .PWRITE          (PWRITE),
    .PADDR           (PADDR),
    .PWDATA          (PWDATA),
    .PRDATA          (PRDATA),
    .PREADY          (PREADY),
    .PSLVERR         (PSLVERR),
    .VIDEO_CLK       (VIDEO_CLK),
    .CORE_CLK        (CORE_CLK),
    .YCM_IN          (YCM_IN),
    .ACTIVE_VIDEO_IN (ACTIVE_VIDEO_IN),
    .VBLANK_IN       (VBLANK_IN),
    .CHROMA_IN       (CHROMA_IN),
    .CONTROL         (CONTROL),
    .FRAME_SIZE      (FRAME_SIZE),
    .BLOCK_SIZE      (BLOCK_SIZE),
    .FRAME_DONE      (FRAME_DONE),
    .FRAME_ERROR     (FRAME_ERROR),
    .REG_UPDATE_DONE (REG_UPDATE_DONE),
    .IRQ_OUT         (IRQ_OUT),
    .LUMA_OUT        (LUMA_OUT),
    .CHROMA_OUT      (CHROMA_OUT),
    .MOTION_OUT      (MOTION_OUT),
    .PIXEL_STROBE    (PIXEL_STROBE)
  );
  ics_vsrc u_ics_vsrc (.vclk(VIDEO_CLK), .ycm(YCM_IN), .act(ACTIVE_VIDEO_IN), .vb(VBLANK_IN), .chr(CHROMA_IN));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    @(posedge CLOCK);
    // only the watchdog ends a wait for the answer
    while (PREADY !== 1'b1) begin
      @(posedge CLOCK);
    end
    chk(PREADY, 1'b1);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
    chk(rerr, a > OFS_PIXCNT);
  endtask
  task automatic frm(input int n, input int e);
    pix_i = 0;
    upd_n = 0;
    u_ics_vsrc.frame(n);
    repeat (4) @(posedge CLOCK);
    chk(pix_i, e);
  endtask
  // update enable is dropped while the block size moves
  task automatic cfg(input logic [31:0] b);
    CONTROL <= 32'h1;
    @(posedge CLOCK);
    BLOCK_SIZE <= b;
    @(posedge CLOCK);
    CONTROL <= 32'h3;
  endtask
  task end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge CLOCK) begin
    if (REG_UPDATE_DONE === 1'b1) upd_n++;
    if (PIXEL_STROBE === 1'b1) begin
      chk(LUMA_OUT, 8'h10 + 8'(pix_i));
      chk(CHROMA_OUT, 8'h80 + 8'(pix_i & ~1));
      chk(MOTION_OUT, 8'h5a);
      pix_i++;
    end
  end
  initial begin
    #200us;
    failures++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    rd(OFS_IRQ_MASK, 32'h0);
    rd(OFS_BSIZE, 32'h10);
    rd(OFS_STATE, 32'h0);
    rd(8'h40, 32'h0);
    FRAME_SIZE <= 32'hf802_f804;
    BLOCK_SIZE <= 32'hffff_ff08;
    frm(0, 0);
    chk(upd_n, 0);
    rd(OFS_FSIZE, 32'h0);
    CONTROL <= 32'h3;
    frm(8, 8);
    chk(upd_n, 1);
    chk(FRAME_DONE, 1'b1);
    rd(OFS_FSIZE, 32'h0002_0004);
    rd(OFS_BSIZE, 32'h8);
    rd(OFS_PIXCNT, 32'h8);
    chk(IRQ_OUT, 1'b0);
    rd(OFS_IRQ_STATUS, 32'h2);
    apb(1'b1, OFS_IRQ_MASK, 32'h2);
    chk(IRQ_OUT, 1'b1);
    apb(1'b1, OFS_IRQ_STATUS, 32'h2);
    chk(IRQ_OUT, 1'b0);
    CONTROL <= 32'h2;
    frm(8, 0);
    chk(FRAME_DONE, 1'b0);
    foreach (sizes[k]) begin
      cfg({25'h0, sizes[k]});
      frm(8, 8);
      rd(OFS_BSIZE, {25'h0, sizes[k]});
      chk(FRAME_ERROR, 1'b0);
    end
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    apb(1'b1, OFS_IRQ_STATUS, 32'h3);
    cfg(32'h5);
    frm(8, 8);
    chk(FRAME_ERROR, 1'b1);
    rd(OFS_BSIZE, 32'h40);
    chk(IRQ_OUT, 1'b0);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    chk(IRQ_OUT, 1'b1);
    apb(1'b1, OFS_IRQ_STATUS, 32'h1);
    chk(IRQ_OUT, 1'b0);
    cfg(32'h4);
    frm(8, 8);
    CE <= 1'b0;
    frm(8, 0);
    chk(FRAME_DONE, 1'b1);
    CE <= 1'b1;
    SCLR <= 1'b1;
    @(posedge CLOCK);
    SCLR <= 1'b0;
    @(posedge CLOCK);
    chk(FRAME_DONE, 1'b0);
    apb(1'b1, OFS_MODE, 32'h1);
    rd(OFS_MODE, 32'h1);
    frm(8, 8);
    chk(FRAME_DONE, 1'b0);
    core_on <= 1'b1;
    repeat (40) @(posedge CLOCK);
    chk(FRAME_DONE, 1'b1);
    end_of_test();
  end
endmodule // ics_top_tb
